// ===== pkg/dcfd_params.svh
// constants for the configuration fuse decoder: fuse byte indices, field positions,
// unprogrammed values, divider ratios and the load sequence length.
// assumes the fuse store answers a byte index with data one clock later.
//
// Notes on behaviour
// (R1) usb clock select 1 halves oscillator for low-speed usb, 0 passes undivided.
// (R2) core divide field: 00 none, 01 by two, 10 by three, 11 by four.
// (R3) switchover mode enabled only while its configuration bit is one.
// (R4) fail-safe clock monitor runs only while its enable bit is one.
// (R5) primary clock forced on when bit is one, else software bit decides.
// (R6) pll bit one always multiplies by four, else software bit decides.
// (R7) four-bit oscillator field decodes into crystal, rc, external clock modes.
// (R8) brown-out level: 11 1.9 V, 10 2.2 V, 01 2.7 V, 00 3.0 V.
// (R9) brown-out mode: hardware, hardware except sleep, software, or disabled.
// (R10) power-up timer runs when its configuration bit is zero.
// (R11) power-up timer and brown-out reset are controlled independently.
// (R12) watchdog postscale ratio is one to two to the power n.
// (R13) watchdog bit one forces watchdog on, else software bit decides.
// (R14) reset pin bit one gives active-low reset, zero gives general input.
// (R15) fast start bit zero lets internal oscillator clock cpu at once.
// (R16) debugger enabled when its active-low bit is zero.
// (R17) extended instruction set enabled when its bit is one.
// (R18) boot block size bit picks 2 kW/1 kW or 1 kW/512 W by variant.
// (R19) low-voltage programming enabled when its bit is one.
// (R20) stack full or underflow resets the device only when bit is one.
// (R21) program blocks 0 and 1 code-protected when their bit is zero.
// (R22) eeprom and boot block code-protected when their bit is zero.
// (R23) fields latched from fuse store after reset and held until next reset.
`ifndef DCFD_PARAMS_SVH
`define DCFD_PARAMS_SVH

// byte indices of the fuse store
`define DCFD_IDX_CLKDIV   4'h0
`define DCFD_IDX_OSC      4'h1
`define DCFD_IDX_BORPWRT  4'h2
`define DCFD_IDX_WDT      4'h3
`define DCFD_IDX_RSTPIN   4'h5
`define DCFD_IDX_DBGBOOT  4'h6
`define DCFD_IDX_CPBLK    4'h8
`define DCFD_IDX_CPEEB    4'h9
`define DCFD_IDX_WPBLK    4'ha
`define DCFD_IDX_LAST     4'ha

// field positions
`define DCFD_USBSEL_BIT   5
`define DCFD_CORDIV_LSB   3
`define DCFD_SWITCH_BIT   7
`define DCFD_MONITOR_BIT  6
`define DCFD_PCLK_BIT     5
`define DCFD_PLL_BIT      4
`define DCFD_OSCSEL_LSB   0
`define DCFD_BORLVL_LSB   3
`define DCFD_BORMODE_LSB  1
`define DCFD_PUTM_BIT     0
`define DCFD_WDSCL_LSB    1
`define DCFD_WDFRC_BIT    0
`define DCFD_RSTPIN_BIT   7
`define DCFD_FASTOSC_BIT  3
`define DCFD_DBG_BIT      7
`define DCFD_XCPU_BIT     6
`define DCFD_BOOTSZ_BIT   3
`define DCFD_LVM_BIT      2
`define DCFD_STACK_BIT    0
`define DCFD_PB1_BIT      1
`define DCFD_PB0_BIT      0
`define DCFD_PEE_BIT      7
`define DCFD_PBB_BIT      6
`define DCFD_WPB1_BIT     1
`define DCFD_WPB0_BIT     0

// unprogrammed (default) byte values, each used until its own byte is loaded
`define DCFD_RST_CLKDIV   8'h00
`define DCFD_RST_OSC      8'h27
`define DCFD_RST_BORPWRT  8'h1f
`define DCFD_RST_WDT      8'h1f
`define DCFD_RST_RSTPIN   8'h88
`define DCFD_RST_DBGBOOT  8'h85
`define DCFD_RST_CPBLK    8'h03
`define DCFD_RST_CPEEB    8'hc0
`define DCFD_RST_WPBLK    8'h03

// fixed ratios
`define DCFD_USB_HALF_DIV 2'd2
`define DCFD_PLL_MULT     3'd4

// boot block sizes in words
`define DCFD_BOOT_2KW     12'd2048
`define DCFD_BOOT_1KW     12'd1024
`define DCFD_BOOT_512W    12'd512

`endif

// ===== pkg/dcfd_pkg.sv
// types for the configuration fuse decoder.
// assumes dcfd_params.svh is included by the design where constants are needed.
package dcfd_pkg;

  // oscillator modes, one per fuse code
  typedef enum logic [3:0] {
    DCFD_OSC_LP         = 4'h0,
    DCFD_OSC_XT         = 4'h1,
    DCFD_OSC_HS         = 4'h2,
    DCFD_OSC_ERC_CO_3   = 4'h3,
    DCFD_OSC_EC_HI_CO   = 4'h4,
    DCFD_OSC_EC_HI      = 4'h5,
    DCFD_OSC_ERC_CO_6   = 4'h6,
    DCFD_OSC_ERC        = 4'h7,
    DCFD_OSC_IRC        = 4'h8,
    DCFD_OSC_IRC_CO     = 4'h9,
    DCFD_OSC_EC_MD_CO   = 4'ha,
    DCFD_OSC_EC_MD      = 4'hb,
    DCFD_OSC_EC_LO_CO   = 4'hc,
    DCFD_OSC_EC_LO      = 4'hd,
    DCFD_OSC_ERC_CO_E   = 4'he,
    DCFD_OSC_ERC_CO_F   = 4'hf
  } dcfd_osc_e;

  // clock source family
  typedef enum logic [2:0] {
    DCFD_SRC_CRYSTAL  = 3'h1,
    DCFD_SRC_EXT_RC   = 3'h2,
    DCFD_SRC_EXT_CLK  = 3'h4
  } dcfd_src_e;

  // loader states, one-hot
  typedef enum logic [2:0] {
    DCFD_ST_FETCH = 3'b001,
    DCFD_ST_STORE = 3'b010,
    DCFD_ST_DONE  = 3'b100
  } dcfd_state_e;

endpackage

// ===== core/dcfd_fuse_decode.sv
// configuration fuse decoder: reads the fuse bytes once after reset and
// drives static control outputs for clocks, resets, watchdog and protection.
// assumes a synchronous fuse store with one-cycle read latency, and software
// control bits arriving from registers on the same clock.
`include "dcfd_params.svh"

module dcfd_fuse_decode (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // fuse store port
  output logic [3:0]       fuse_index_o,
  input  wire logic [7:0]  fuse_data_i,
  // software control bits and event inputs (sleep, stack fault, reset pin)
  input  wire logic        primary_clock_soft_i,
  input  wire logic        multiplier_soft_i,
  input  wire logic        brownout_soft_enable_i,
  input  wire logic        watchdog_soft_enable_i,
  input  wire logic        sleep_i,
  input  wire logic        stack_fault_i,
  input  wire logic        reset_pin_n_i,
  // status
  output logic             config_valid_o,
  // clocking
  output logic             usb_lowspeed_clk_half_o,
  output logic [1:0]       usb_clock_divide_o,
  output logic [1:0]       core_clock_divide_o,
  output logic [2:0]       core_clock_ratio_o,
  output logic             osc_switchover_enable_o,
  output logic             clock_monitor_enable_o,
  output logic             primary_clock_run_o,
  output logic             multiplier_run_o,
  output logic [2:0]       multiplier_ratio_o,
  output logic [3:0]       oscillator_mode_select_o,
  output logic [2:0]       oscillator_source_o,
  output logic             clock_output_function_o,
  output logic             fast_osc_start_o,
  // brown-out and power-up
  output logic [1:0]       brownout_level_select_o,
  output logic [1:0]       brownout_enable_mode_o,
  output logic             brownout_active_o,
  output logic             powerup_timer_enable_o,
  // watchdog
  output logic [3:0]       watchdog_postscale_select_o,
  output logic [15:0]      watchdog_postscale_ratio_m1_o,
  output logic             watchdog_run_o,
  // reset pin
  output logic             reset_pin_enable_o,
  output logic             shared_input_pin_enable_o,
  output logic             external_reset_o,
  // cpu and debug
  output logic             debugger_enable_o,
  output logic             extended_cpu_enable_o,
  output logic             boot_block_size_select_o,
  output logic [11:0]      boot_block_words_large_o,
  output logic [11:0]      boot_block_words_small_o,
  output logic             low_voltage_program_enable_o,
  output logic             stack_fault_reset_enable_o,
  output logic             stack_fault_reset_o,
  // protection
  output logic             block0_code_protect_o,
  output logic             block1_code_protect_o,
  output logic             eeprom_code_protect_o,
  output logic             boot_code_protect_o,
  output logic             block0_write_protect_o,
  output logic             block1_write_protect_o
);

  dcfd_pkg::dcfd_state_e state_q;
  logic [3:0]            index_q;
  logic                  pend_q;
  logic [7:0]            clock_divider_config_q;
  logic [7:0]            oscillator_config_q;
  logic [7:0]            brownout_powerup_config_q;
  logic [7:0]            watchdog_config_q;
  logic [7:0]            reset_pin_startup_config_q;
  logic [7:0]            debug_cpu_boot_config_q;
  logic [7:0]            block_code_protect_q;
  logic [7:0]            eeprom_boot_code_protect_q;
  logic [7:0]            block_write_protect_q;
  logic                  pin_meta_q;
  logic                  pin_sync_q;
  logic                  osc_co;
  dcfd_pkg::dcfd_src_e   osc_src;

  // (R23) load sequencer walks fuse indices once per reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= dcfd_pkg::DCFD_ST_FETCH;
      index_q <= 4'h0;
      pend_q  <= 1'b0;
    end else begin
      case (state_q)
        dcfd_pkg::DCFD_ST_FETCH: begin
          pend_q  <= 1'b1;
          state_q <= dcfd_pkg::DCFD_ST_STORE;
        end
        dcfd_pkg::DCFD_ST_STORE: begin
          pend_q <= 1'b0;
          if (index_q == `DCFD_IDX_LAST) begin
            state_q <= dcfd_pkg::DCFD_ST_DONE;
          end else begin
            index_q <= index_q + 4'h1;
            state_q <= dcfd_pkg::DCFD_ST_FETCH;
          end
        end
        dcfd_pkg::DCFD_ST_DONE: begin
          pend_q <= 1'b0;
        end
        default: begin
          state_q <= dcfd_pkg::DCFD_ST_FETCH;
          index_q <= 4'h0;
          pend_q  <= 1'b0;
        end
      endcase
    end
  end

  // (R23) capture each fuse byte; unprogrammed values hold until loaded
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_divider_config_q     <= `DCFD_RST_CLKDIV;
      oscillator_config_q        <= `DCFD_RST_OSC;
      brownout_powerup_config_q  <= `DCFD_RST_BORPWRT;
      watchdog_config_q          <= `DCFD_RST_WDT;
      reset_pin_startup_config_q <= `DCFD_RST_RSTPIN;
      debug_cpu_boot_config_q    <= `DCFD_RST_DBGBOOT;
      block_code_protect_q       <= `DCFD_RST_CPBLK;
      eeprom_boot_code_protect_q <= `DCFD_RST_CPEEB;
      block_write_protect_q      <= `DCFD_RST_WPBLK;
    end else if (pend_q && state_q == dcfd_pkg::DCFD_ST_STORE) begin
      case (index_q)
        `DCFD_IDX_CLKDIV:  clock_divider_config_q     <= fuse_data_i & 8'h38;
        `DCFD_IDX_OSC:     oscillator_config_q        <= fuse_data_i;
        `DCFD_IDX_BORPWRT: brownout_powerup_config_q  <= fuse_data_i & 8'h1f;
        `DCFD_IDX_WDT:     watchdog_config_q          <= fuse_data_i & 8'h1f;
        `DCFD_IDX_RSTPIN:  reset_pin_startup_config_q <= fuse_data_i & 8'h88;
        `DCFD_IDX_DBGBOOT: debug_cpu_boot_config_q    <= fuse_data_i & 8'hcd;
        `DCFD_IDX_CPBLK:   block_code_protect_q       <= fuse_data_i & 8'h03;
        `DCFD_IDX_CPEEB:   eeprom_boot_code_protect_q <= fuse_data_i & 8'hc0;
        `DCFD_IDX_WPBLK:   block_write_protect_q      <= fuse_data_i & 8'h03;
        default: begin
        end
      endcase
    end
  end

  // reset pin is asynchronous to the clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end else begin
      pin_meta_q <= reset_pin_n_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // (R7) oscillator family and clock-out decode
  always_comb begin
    osc_co  = 1'b0;
    osc_src = dcfd_pkg::DCFD_SRC_EXT_RC;
    case (dcfd_pkg::dcfd_osc_e'(oscillator_config_q[`DCFD_OSCSEL_LSB +: 4]))
      dcfd_pkg::DCFD_OSC_LP, dcfd_pkg::DCFD_OSC_XT, dcfd_pkg::DCFD_OSC_HS: begin
        osc_src = dcfd_pkg::DCFD_SRC_CRYSTAL;
      end
      dcfd_pkg::DCFD_OSC_IRC: begin
        osc_src = dcfd_pkg::DCFD_SRC_CRYSTAL;
      end
      dcfd_pkg::DCFD_OSC_IRC_CO: begin
        osc_src = dcfd_pkg::DCFD_SRC_CRYSTAL;
        osc_co  = 1'b1;
      end
      dcfd_pkg::DCFD_OSC_EC_HI, dcfd_pkg::DCFD_OSC_EC_MD, dcfd_pkg::DCFD_OSC_EC_LO: begin
        osc_src = dcfd_pkg::DCFD_SRC_EXT_CLK;
      end
      dcfd_pkg::DCFD_OSC_EC_HI_CO, dcfd_pkg::DCFD_OSC_EC_MD_CO, dcfd_pkg::DCFD_OSC_EC_LO_CO: begin
        osc_src = dcfd_pkg::DCFD_SRC_EXT_CLK;
        osc_co  = 1'b1;
      end
      dcfd_pkg::DCFD_OSC_ERC: begin
        osc_src = dcfd_pkg::DCFD_SRC_EXT_RC;
      end
      default: begin
        osc_src = dcfd_pkg::DCFD_SRC_EXT_RC;
        osc_co  = 1'b1;
      end
    endcase
  end

  // clock outputs registered from the latched bytes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      usb_lowspeed_clk_half_o  <= 1'b0;
      usb_clock_divide_o       <= 2'd1;
      core_clock_divide_o      <= 2'd0;
      core_clock_ratio_o       <= 3'd1;
      osc_switchover_enable_o  <= 1'b0;
      clock_monitor_enable_o   <= 1'b0;
      primary_clock_run_o      <= 1'b1;
      multiplier_run_o         <= 1'b0;
      multiplier_ratio_o       <= 3'd1;
      oscillator_mode_select_o <= 4'h7;
      oscillator_source_o      <= dcfd_pkg::DCFD_SRC_EXT_RC;
      clock_output_function_o  <= 1'b0;
      fast_osc_start_o         <= 1'b0;
    end else begin
      // (R1) usb low-speed divide
      usb_lowspeed_clk_half_o <= clock_divider_config_q[`DCFD_USBSEL_BIT];
      usb_clock_divide_o      <= clock_divider_config_q[`DCFD_USBSEL_BIT] ? `DCFD_USB_HALF_DIV : 2'd1;
      // (R2) core divide ratio
      core_clock_divide_o <= clock_divider_config_q[`DCFD_CORDIV_LSB +: 2];
      core_clock_ratio_o  <= {1'b0, clock_divider_config_q[`DCFD_CORDIV_LSB +: 2]} + 3'd1;
      // (R3) switchover gate
      osc_switchover_enable_o <= oscillator_config_q[`DCFD_SWITCH_BIT];
      // (R4) fail-safe monitor gate
      clock_monitor_enable_o <= oscillator_config_q[`DCFD_MONITOR_BIT];
      // (R5) primary clock force or software
      primary_clock_run_o <= oscillator_config_q[`DCFD_PCLK_BIT] | primary_clock_soft_i;
      // (R6) pll force or software
      multiplier_run_o   <= oscillator_config_q[`DCFD_PLL_BIT] | multiplier_soft_i;
      multiplier_ratio_o <= (oscillator_config_q[`DCFD_PLL_BIT] | multiplier_soft_i) ? `DCFD_PLL_MULT : 3'd1;
      // (R7) oscillator mode and clock-out
      oscillator_mode_select_o <= oscillator_config_q[`DCFD_OSCSEL_LSB +: 4];
      oscillator_source_o      <= osc_src;
      clock_output_function_o  <= osc_co;
      // (R15) fast start when bit is zero
      fast_osc_start_o <= ~reset_pin_startup_config_q[`DCFD_FASTOSC_BIT];
    end
  end

  // reset-related and watchdog outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      brownout_level_select_o       <= 2'b11;
      brownout_enable_mode_o        <= 2'b11;
      brownout_active_o             <= 1'b1;
      powerup_timer_enable_o        <= 1'b0;
      watchdog_postscale_select_o   <= 4'hf;
      watchdog_postscale_ratio_m1_o <= 16'h7fff;
      watchdog_run_o                <= 1'b1;
      reset_pin_enable_o            <= 1'b1;
      shared_input_pin_enable_o     <= 1'b0;
      external_reset_o              <= 1'b0;
      stack_fault_reset_enable_o    <= 1'b1;
      stack_fault_reset_o           <= 1'b0;
    end else begin
      // (R8) trip level code passed through
      brownout_level_select_o <= brownout_powerup_config_q[`DCFD_BORLVL_LSB +: 2];
      brownout_enable_mode_o  <= brownout_powerup_config_q[`DCFD_BORMODE_LSB +: 2];
      // (R9) brown-out enable modes
      case (brownout_powerup_config_q[`DCFD_BORMODE_LSB +: 2])
        2'b11:   brownout_active_o <= 1'b1;
        2'b10:   brownout_active_o <= ~sleep_i;
        2'b01:   brownout_active_o <= brownout_soft_enable_i;
        default: brownout_active_o <= 1'b0;
      endcase
      // (R10) (R11) power-up timer from its own bit only
      powerup_timer_enable_o <= ~brownout_powerup_config_q[`DCFD_PUTM_BIT];
      // (R12) postscale ratio minus one, 2^n - 1
      watchdog_postscale_select_o   <= watchdog_config_q[`DCFD_WDSCL_LSB +: 4];
      watchdog_postscale_ratio_m1_o <= 16'((17'h1 << watchdog_config_q[`DCFD_WDSCL_LSB +: 4]) - 17'h1);
      // (R13) watchdog force or software
      watchdog_run_o <= watchdog_config_q[`DCFD_WDFRC_BIT] | watchdog_soft_enable_i;
      // (R14) reset pin versus input pin
      reset_pin_enable_o        <= reset_pin_startup_config_q[`DCFD_RSTPIN_BIT];
      shared_input_pin_enable_o <= ~reset_pin_startup_config_q[`DCFD_RSTPIN_BIT];
      external_reset_o          <= reset_pin_startup_config_q[`DCFD_RSTPIN_BIT] & ~pin_sync_q;
      // (R20) stack fault reset gate
      stack_fault_reset_enable_o <= debug_cpu_boot_config_q[`DCFD_STACK_BIT];
      stack_fault_reset_o        <= debug_cpu_boot_config_q[`DCFD_STACK_BIT] & stack_fault_i;
    end
  end

  // cpu, boot and protection outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      debugger_enable_o            <= 1'b0;
      extended_cpu_enable_o        <= 1'b0;
      boot_block_size_select_o     <= 1'b0;
      boot_block_words_large_o     <= `DCFD_BOOT_1KW;
      boot_block_words_small_o     <= `DCFD_BOOT_512W;
      low_voltage_program_enable_o <= 1'b1;
      block0_code_protect_o        <= 1'b0;
      block1_code_protect_o        <= 1'b0;
      eeprom_code_protect_o        <= 1'b0;
      boot_code_protect_o          <= 1'b0;
      block0_write_protect_o       <= 1'b0;
      block1_write_protect_o       <= 1'b0;
    end else begin
      // (R16) debugger active-low bit
      debugger_enable_o <= ~debug_cpu_boot_config_q[`DCFD_DBG_BIT];
      // (R17) extended instruction set
      extended_cpu_enable_o <= debug_cpu_boot_config_q[`DCFD_XCPU_BIT];
      // (R18) boot block size per variant
      boot_block_size_select_o <= debug_cpu_boot_config_q[`DCFD_BOOTSZ_BIT];
      boot_block_words_large_o <= debug_cpu_boot_config_q[`DCFD_BOOTSZ_BIT] ? `DCFD_BOOT_2KW : `DCFD_BOOT_1KW;
      boot_block_words_small_o <= debug_cpu_boot_config_q[`DCFD_BOOTSZ_BIT] ? `DCFD_BOOT_1KW : `DCFD_BOOT_512W;
      // (R19) low-voltage programming
      low_voltage_program_enable_o <= debug_cpu_boot_config_q[`DCFD_LVM_BIT];
      // (R21) block code protection, active low bits
      block0_code_protect_o <= ~block_code_protect_q[`DCFD_PB0_BIT];
      block1_code_protect_o <= ~block_code_protect_q[`DCFD_PB1_BIT];
      // (R22) eeprom and boot block protection, then block write protection
      eeprom_code_protect_o <= ~eeprom_boot_code_protect_q[`DCFD_PEE_BIT];
      boot_code_protect_o   <= ~eeprom_boot_code_protect_q[`DCFD_PBB_BIT];
      block0_write_protect_o <= ~block_write_protect_q[`DCFD_WPB0_BIT];
      block1_write_protect_o <= ~block_write_protect_q[`DCFD_WPB1_BIT];
    end
  end

  // fuse index and load-complete flag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fuse_index_o   <= 4'h0;
      config_valid_o <= 1'b0;
    end else begin
      fuse_index_o   <= (state_q == dcfd_pkg::DCFD_ST_STORE && index_q != `DCFD_IDX_LAST) ? index_q + 4'h1 : index_q;
      config_valid_o <= (state_q == dcfd_pkg::DCFD_ST_DONE);
    end
  end

endmodule

// ===== testbench/dcfd_fuse_checker.sv
// checker for the configuration fuse decoder: port relations over time.
// assumes it is bound to every dcfd_fuse_decode instance, one clock domain.
module dcfd_fuse_checker (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        config_valid_o,
  input wire logic        usb_lowspeed_clk_half_o,
  input wire logic [1:0]  usb_clock_divide_o,
  input wire logic [1:0]  core_clock_divide_o,
  input wire logic [2:0]  core_clock_ratio_o,
  input wire logic        primary_clock_soft_i,
  input wire logic        primary_clock_run_o,
  input wire logic        watchdog_soft_enable_i,
  input wire logic        watchdog_run_o,
  input wire logic [3:0]  watchdog_postscale_select_o,
  input wire logic [15:0] watchdog_postscale_ratio_m1_o,
  input wire logic [1:0]  brownout_enable_mode_o,
  input wire logic        brownout_active_o,
  input wire logic        reset_pin_enable_o,
  input wire logic        external_reset_o,
  input wire logic        stack_fault_reset_enable_o,
  input wire logic        stack_fault_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // decoded outputs against their causes
  property p_usb_div;
    usb_clock_divide_o == (usb_lowspeed_clk_half_o ? 2'd2 : 2'd1);
  endproperty
  a_usb_div: assert property (p_usb_div) else $error("usb divide mismatch");
  property p_core_ratio;
    config_valid_o |-> core_clock_ratio_o == {1'b0, core_clock_divide_o} + 3'd1;
  endproperty
  a_core_ratio: assert property (p_core_ratio) else $error("core ratio mismatch");
  property p_primary_soft;
    config_valid_o && primary_clock_soft_i |=> primary_clock_run_o;
  endproperty
  a_primary_soft: assert property (p_primary_soft) else $error("primary clock not running");
  property p_wdt_ratio;
    watchdog_postscale_ratio_m1_o == 16'((17'd1 << watchdog_postscale_select_o) - 17'd1);
  endproperty
  a_wdt_ratio: assert property (p_wdt_ratio) else $error("postscale ratio mismatch");
  property p_wdt_soft;
    watchdog_soft_enable_i |=> watchdog_run_o;
  endproperty
  a_wdt_soft: assert property (p_wdt_soft) else $error("watchdog not running");
  property p_bor_off;
    config_valid_o && brownout_enable_mode_o == 2'b00 |-> !brownout_active_o [*3];
  endproperty
  a_bor_off: assert property (p_bor_off) else $error("brown-out active while disabled");
  property p_pin_input;
    config_valid_o && !reset_pin_enable_o |-> !external_reset_o;
  endproperty
  a_pin_input: assert property (p_pin_input) else $error("external reset while pin is input");
  property p_stack_off;
    config_valid_o && !stack_fault_reset_enable_o |-> !stack_fault_reset_o;
  endproperty
  a_stack_off: assert property (p_stack_off) else $error("stack reset while disabled");
  property p_cfg_hold;
    config_valid_o |=> config_valid_o && $stable(watchdog_postscale_select_o) && $stable(core_clock_divide_o);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("configuration changed after load");
  property p_load_time;
    $rose(rst_n_i) |-> ##[2:40] config_valid_o;
  endproperty
  a_load_time: assert property (p_load_time) else $error("configuration load too slow");
endmodule

bind dcfd_fuse_decode dcfd_fuse_checker chk_u (
  .clk_i, .rst_n_i, .config_valid_o, .usb_lowspeed_clk_half_o, .usb_clock_divide_o, .core_clock_divide_o,
  .core_clock_ratio_o, .primary_clock_soft_i, .primary_clock_run_o, .watchdog_soft_enable_i, .watchdog_run_o,
  .watchdog_postscale_select_o, .watchdog_postscale_ratio_m1_o, .brownout_enable_mode_o, .brownout_active_o,
  .reset_pin_enable_o, .external_reset_o, .stack_fault_reset_enable_o, .stack_fault_reset_o
);

// ===== testbench/tb.sv
// self-checking bench for the configuration fuse decoder: loads sixteen fuse images.
// assumes the checker binds itself; the bench models the fuse store.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic [3:0]        fuse_index_o;
  logic [7:0]        fuse_data_i = 8'h00;
  logic              sw = 1'b0;
  logic              flip = 1'b0;
  logic [7:0]        img [0:10];
  int                failures = 0;
  int                checks = 0;
  localparam logic [15:0] ec_codes  = 16'h3c30;
  localparam logic [15:0] erc_codes = 16'hc0c8;
  localparam logic [15:0] out_codes = 16'hd658;

  always #4 clk_i = ~clk_i;

  // fuse store: one-clock read latency, inverted content once loaded
  always @(posedge clk_i) fuse_data_i <= flip ? ~img[fuse_index_o] : img[fuse_index_o];

  dcfd_fuse_decode dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .fuse_index_o(fuse_index_o), .fuse_data_i(fuse_data_i),
    .primary_clock_soft_i(sw), .multiplier_soft_i(sw), .brownout_soft_enable_i(sw), .watchdog_soft_enable_i(sw),
    .sleep_i(sw), .stack_fault_i(sw), .reset_pin_n_i(!sw), .config_valid_o(), .usb_lowspeed_clk_half_o(),
    .usb_clock_divide_o(), .core_clock_divide_o(), .core_clock_ratio_o(), .osc_switchover_enable_o(),
    .clock_monitor_enable_o(), .primary_clock_run_o(), .multiplier_run_o(), .multiplier_ratio_o(),
    .oscillator_mode_select_o(), .oscillator_source_o(), .clock_output_function_o(), .fast_osc_start_o(),
    .brownout_level_select_o(), .brownout_enable_mode_o(), .brownout_active_o(), .powerup_timer_enable_o(),
    .watchdog_postscale_select_o(), .watchdog_postscale_ratio_m1_o(), .watchdog_run_o(), .reset_pin_enable_o(),
    .shared_input_pin_enable_o(), .external_reset_o(), .debugger_enable_o(), .extended_cpu_enable_o(),
    .boot_block_size_select_o(), .boot_block_words_large_o(), .boot_block_words_small_o(),
    .low_voltage_program_enable_o(), .stack_fault_reset_enable_o(), .stack_fault_reset_o(),
    .block0_code_protect_o(), .block1_code_protect_o(), .eeprom_code_protect_o(), .boot_code_protect_o(),
    .block0_write_protect_o(), .block1_write_protect_o()
  );

  // compare one value and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // print counts and verdict, then stop
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // build an image from v, reset, and wait for the load
  task automatic load(input logic [3:0] v);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    sw <= 1'b0;
    flip <= 1'b0;
    img = '{{2'b00, v[0], v[1:0], 3'b000}, {v, v}, {3'b000, v[1:0], v[3:2], v[0]}, {3'b000, v, v[0] ^ v[1]},
            8'hff, {v[0], 3'b000, v[1], 3'b000}, {v[0], v[1], 2'b00, v[2], v[3], 1'b0, v[0] ^ v[3]}, 8'hff,
            {6'h00, v[1:0]}, {v[2], v[3], 6'h00}, {6'h00, v[3:2]}};
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int n = 0; n < 40 && dut_u.config_valid_o !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    chk("config_valid", dut_u.config_valid_o, 1'b1);
  endtask

  // compare every decoded output with the image and the software level sw
  task automatic verify();
    logic [3:0] m;
    logic [1:0] bm;
    m = img[1][3:0];
    bm = img[2][2:1];
    chk("clk_div", {dut_u.usb_lowspeed_clk_half_o, dut_u.usb_clock_divide_o, dut_u.core_clock_divide_o,
        dut_u.core_clock_ratio_o}, {img[0][5], img[0][5] ? 2'd2 : 2'd1, img[0][4:3], {1'b0, img[0][4:3]} + 3'd1});
    chk("osc", {dut_u.osc_switchover_enable_o, dut_u.clock_monitor_enable_o, dut_u.primary_clock_run_o,
        dut_u.multiplier_run_o, dut_u.multiplier_ratio_o}, {img[1][7:6], img[1][5] | sw, img[1][4] | sw,
        (img[1][4] | sw) ? 3'd4 : 3'd1});
    chk("osc_mode", {dut_u.oscillator_mode_select_o, dut_u.oscillator_source_o, dut_u.clock_output_function_o},
        {m, ec_codes[m], erc_codes[m], !(ec_codes[m] | erc_codes[m]), out_codes[m]});
    chk("bor", {dut_u.brownout_level_select_o, dut_u.brownout_enable_mode_o, dut_u.brownout_active_o,
        dut_u.powerup_timer_enable_o}, {img[2][4:1], bm == 2'b11 || (bm == 2'b10 && !sw) || (bm == 2'b01 && sw),
        ~img[2][0]});
    chk("wdt", {dut_u.watchdog_postscale_select_o, dut_u.watchdog_postscale_ratio_m1_o, dut_u.watchdog_run_o},
        {img[3][4:1], 16'((17'd1 << img[3][4:1]) - 17'd1), img[3][0] | sw});
    chk("pin", {dut_u.reset_pin_enable_o, dut_u.shared_input_pin_enable_o, dut_u.external_reset_o,
        dut_u.fast_osc_start_o}, {img[5][7], ~img[5][7], img[5][7] & sw, ~img[5][3]});
    chk("cpu", {dut_u.debugger_enable_o, dut_u.extended_cpu_enable_o, dut_u.boot_block_size_select_o,
        dut_u.boot_block_words_large_o, dut_u.boot_block_words_small_o, dut_u.low_voltage_program_enable_o,
        dut_u.stack_fault_reset_enable_o, dut_u.stack_fault_reset_o}, {~img[6][7], img[6][6], img[6][3],
        img[6][3] ? 12'd2048 : 12'd1024, img[6][3] ? 12'd1024 : 12'd512, img[6][2], img[6][0], img[6][0] & sw});
    chk("protect", {dut_u.block0_code_protect_o, dut_u.block1_code_protect_o, dut_u.eeprom_code_protect_o,
        dut_u.boot_code_protect_o, dut_u.block0_write_protect_o, dut_u.block1_write_protect_o},
        {~img[8][0], ~img[8][1], ~img[9][7], ~img[9][6], ~img[10][0], ~img[10][1]});
  endtask

  // main sequence: unprogrammed decode in reset, then sixteen images
  initial begin
    repeat (10) @(posedge clk_i);
    #1;
    chk("reset_view", {dut_u.config_valid_o, dut_u.fuse_index_o, dut_u.watchdog_postscale_ratio_m1_o,
        dut_u.watchdog_run_o}, {1'b0, 4'h0, 16'h7fff, 1'b1});
    for (int i = 0; i < 16; i++) begin
      load(4'(i));
      verify();
      @(posedge clk_i);
      sw <= 1'b1;
      flip <= 1'b1;
      repeat (5) @(posedge clk_i);
      #1;
      verify();
    end
    give_verdict();
  end

  // watchdog: the run needs under 6 us, so 50 us means a hang
  initial begin
    #50us;
    failures++;
    give_verdict();
  end
endmodule
